// ===== rtl/mla_core.sv
// Purpose: multiplicand load and accumulate datapath
// Assumes: memory answers a read one cycle after the request
// Notes:   decoder issues one command when busy is low
//
// Notes on behaviour
// - Load instructions copy the addressed data word into the factor register.
// - Load-add-move adds the mode-shifted product into the accumulator.
// - Load-add-move writes the data word to the next higher address.
// - Move allowed in block two and in block one except its last word, block zero only as data.
// - Move from last word of block zero into block one works while block zero is data.
// - No move for external memory or memory-mapped registers.
// - Load-add-move on external memory acts as plain load-and-add.
// - Multiply-accumulate takes a program address and a data address.
// - Multiply-accumulate multiplies operands and adds previous shifted product.
// - Repeated multiply-accumulate increments program address each iteration.
`timescale 1ns/1ns
`default_nettype none
module mla_core
	import mla_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	input  wire mla_pkg::mla_cmd_t     cmd,
	output logic                       busy,
	output mla_pkg::mla_mem_req_t      mem_req,
	input  wire logic [15:0]           mem_rdata,
	input  wire logic [3:0]            reg_addr,
	input  wire logic [15:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [15:0]           reg_rdata
);
	import mla_pkg::*;

	typedef enum logic [2:0] {
		MLA_ST_IDLE,
		MLA_ST_FETCH_D,
		MLA_ST_FETCH_P,
		MLA_ST_EXEC,
		MLA_ST_MOVE
	} mla_state_t;

	typedef struct packed {
		mla_state_t    st;
		mla_op_t       op;
		logic [15:0]   dma;
		logic [15:0]   pma;
		logic [7:0]    rpt;
		logic [15:0]   dword;
		logic [15:0]   factor;
		logic [31:0]   prod;
		logic [31:0]   acc;
		logic          carry;
		logic          excess_flag;
		logic [15:0]   ctrl;
		logic [15:0]   rdata;
		mla_mem_req_t  req;
	} mla_state_s_t;

	mla_state_s_t r;
	mla_state_s_t next_r;
	logic [31:0]  shifted;
	logic [1:0]   product_shift_mode;
	logic         saturation_enable;
	logic         block_zero_program_select;
	logic         move_ok;
	logic [32:0]  sum;
	logic [31:0]  addend;
	logic         ovf;

	assign product_shift_mode        = r.ctrl[MLA_CTRL_PM_LSB +: 2];
	assign saturation_enable         = r.ctrl[MLA_CTRL_SAT_BIT];
	assign block_zero_program_select = r.ctrl[MLA_CTRL_CNF_BIT];
	assign busy      = (r.st != MLA_ST_IDLE);
	assign mem_req   = r.req;
	assign reg_rdata = r.rdata;

	// Product shifter
	mla_shift u_shift (
		.product            (r.prod),
		.product_shift_mode (product_shift_mode),
		.shifted            (shifted)
	);

	////////////////////////////////////////////////////////////////////
	// Move eligibility by address region
	// block region check
	always_comb begin
		move_ok = 1'b0;
		if (r.dma >= MLA_B2_LO && r.dma <= MLA_B2_HI)
			move_ok = 1'b1;
		else if (r.dma >= MLA_B0_LO && r.dma <= MLA_B0_HI)
			move_ok = !block_zero_program_select;
		else if (r.dma > MLA_B0_HI && r.dma < MLA_B1_HI)
			move_ok = 1'b1;
		if (r.dma <= MLA_MMR_TOP)
			move_ok = 1'b0;
	end

	// Accumulator adder, subtract for load-and-subtract
	// subtract shifted product
	always_comb begin
		addend = (r.op == MLA_OP_LOAD_SUB) ? ~shifted : shifted;
		sum    = {1'b0, r.acc} + {1'b0, addend} + {32'h0, (r.op == MLA_OP_LOAD_SUB)};
		ovf    = (r.acc[31] == addend[31]) && (sum[31] != r.acc[31]);
	end

	////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_r         = r;
		next_r.req.rd  = 1'b0;
		next_r.req.wr  = 1'b0;
		next_r.rdata   = 16'h0000;
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				MLA_OFS_CTRL:    next_r.ctrl = reg_wdata;
				MLA_OFS_ACC_LO:  next_r.acc[15:0] = reg_wdata;
				MLA_OFS_ACC_HI:  next_r.acc[31:16] = reg_wdata;
				MLA_OFS_FACTOR:  next_r.factor = reg_wdata;
				MLA_OFS_PROD_LO: next_r.prod[15:0] = reg_wdata;
				MLA_OFS_PROD_HI: next_r.prod[31:16] = reg_wdata;
				default: ;
			endcase
		end
		// Register reads, unmapped reads zero
		if (reg_rd) begin
			case (reg_addr)
				MLA_OFS_CTRL:    next_r.rdata = r.ctrl;
				MLA_OFS_ACC_LO:  next_r.rdata = r.acc[15:0];
				MLA_OFS_ACC_HI:  next_r.rdata = r.acc[31:16];
				MLA_OFS_FACTOR:  next_r.rdata = r.factor;
				MLA_OFS_PROD_LO: next_r.rdata = r.prod[15:0];
				MLA_OFS_PROD_HI: next_r.rdata = r.prod[31:16];
				MLA_OFS_STATUS:  next_r.rdata = {13'h0, busy, r.excess_flag, r.carry};
				default:         next_r.rdata = 16'h0000;
			endcase
		end
		case (r.st)
			MLA_ST_IDLE: begin
				if (cmd.valid) begin
					next_r.op       = cmd.op;
					next_r.dma      = cmd.dma;
					next_r.pma      = cmd.pma;
					next_r.rpt      = cmd.repeat_count;
					next_r.req.rd   = 1'b1;
					next_r.req.prog = 1'b0;
					next_r.req.addr = cmd.dma;
					next_r.st       = MLA_ST_FETCH_D;
				end
			end
			MLA_ST_FETCH_D: begin
				next_r.dword = mem_rdata;
				if (r.op == MLA_OP_MULACC) begin
					next_r.req.rd   = 1'b1;
					next_r.req.prog = 1'b1;
					next_r.req.addr = r.pma;
					next_r.st       = MLA_ST_FETCH_P;
				end else begin
					next_r.st = MLA_ST_EXEC;
				end
			end
			MLA_ST_FETCH_P: begin
				next_r.acc = sum[31:0];
				next_r.carry = sum[32];
				if (ovf)
					next_r.excess_flag = 1'b1;
				if (ovf && saturation_enable)
					next_r.acc = r.acc[31] ? 32'h80000000 : 32'h7FFFFFFF;
				next_r.factor = r.dword;
				next_r.prod   = 32'($signed(r.dword)) * 32'($signed(mem_rdata));
				if (r.rpt != 8'h00) begin
					next_r.rpt      = r.rpt - 8'h01;
					next_r.pma      = r.pma + 16'h0001;
					next_r.req.rd   = 1'b1;
					next_r.req.prog = 1'b0;
					next_r.req.addr = r.dma;
					next_r.st       = MLA_ST_FETCH_D;
				end else begin
					next_r.st = MLA_ST_IDLE;
				end
			end
			MLA_ST_EXEC: begin
				next_r.factor = r.dword;
				next_r.st     = MLA_ST_IDLE;
				case (r.op)
					MLA_OP_LOAD_ADD, MLA_OP_LOAD_ADD_MOVE, MLA_OP_LOAD_SUB: begin
						next_r.acc   = sum[31:0];
						next_r.carry = (r.op == MLA_OP_LOAD_SUB) ? sum[32] : sum[32];
						if (ovf)
							next_r.excess_flag = 1'b1;
						if (ovf && saturation_enable)
							next_r.acc = r.acc[31] ? 32'h80000000 : 32'h7FFFFFFF;
					end
					MLA_OP_LOAD_COPY: next_r.acc = shifted;
					default: ;
				endcase
				if (r.op == MLA_OP_LOAD_ADD_MOVE && move_ok) begin
					next_r.req.wr    = 1'b1;
					next_r.req.prog  = 1'b0;
					next_r.req.addr  = r.dma + 16'h0001;
					next_r.req.wdata = r.dword;
					next_r.st        = MLA_ST_MOVE;
				end
			end
			MLA_ST_MOVE: next_r.st = MLA_ST_IDLE;
			default: next_r.st = MLA_ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.ctrl <= MLA_CTRL_RST;
			r.st <= MLA_ST_IDLE;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions
	a_factor_load: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_EXEC) |=> (r.factor == $past(r.dword)))
		else $error("factor not loaded");
	a_copy_flags: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_EXEC && r.op == MLA_OP_LOAD_COPY) |=>
		($stable(r.carry) && $stable(r.excess_flag)))
		else $error("copy changed flags");
	a_move_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.req.wr) |-> (r.req.addr == r.dma + 16'h0001 && r.req.wdata == r.dword))
		else $error("move address wrong");
	a_move_region: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.req.wr) |-> (r.dma > MLA_MMR_TOP))
		else $error("move into mapped area");
	a_no_move_plain: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_EXEC && r.op != MLA_OP_LOAD_ADD_MOVE) |=> !r.req.wr)
		else $error("unexpected move");
	a_b0_prog: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.req.wr && r.dma >= MLA_B0_LO && r.dma <= MLA_B0_HI) |-> !block_zero_program_select)
		else $error("move in program block");
	a_pma_step: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_FETCH_P && r.rpt != 8'h00) |=> (r.pma == $past(r.pma) + 16'h0001))
		else $error("table address not stepped");
	a_mac_fetch: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_FETCH_D && r.op == MLA_OP_MULACC) |=>
		(r.req.rd && r.req.prog && r.st == MLA_ST_FETCH_P))
		else $error("no table fetch");
	a_mac_done: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_FETCH_P && r.rpt == 8'h00) |=> (r.st == MLA_ST_IDLE))
		else $error("mac did not finish");

	// Accumulator and move results, checked against the operands of the previous cycle
	// plain add sum
	a_add_sum: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_EXEC && r.op == MLA_OP_LOAD_ADD && !ovf) |=>
		(r.acc == $past(r.acc) + $past(shifted)))
		else $error("add result wrong");
	a_move_sum: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_EXEC && r.op == MLA_OP_LOAD_ADD_MOVE && !ovf) |=>
		(r.acc == $past(r.acc) + $past(shifted)))
		else $error("move add result wrong");
	a_sub_diff: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_EXEC && r.op == MLA_OP_LOAD_SUB && !ovf) |=>
		(r.acc == $past(r.acc) - $past(shifted)))
		else $error("subtract result wrong");
	a_sub_clamp: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_EXEC && r.op == MLA_OP_LOAD_SUB && ovf && saturation_enable) |=>
		((r.acc == 32'h80000000 || r.acc == 32'h7FFFFFFF) && r.excess_flag))
		else $error("subtract not clamped");
	a_copy_value: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_EXEC && r.op == MLA_OP_LOAD_COPY) |=>
		(r.acc == $past(shifted)))
		else $error("copy result wrong");
	a_edge_move: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_EXEC && r.op == MLA_OP_LOAD_ADD_MOVE && r.dma == MLA_B0_HI &&
		!block_zero_program_select) |=> (r.req.wr && r.req.addr == MLA_B0_HI + 16'h0001))
		else $error("boundary move missing");
	a_ext_plain: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_EXEC && r.op == MLA_OP_LOAD_ADD_MOVE && r.dma > MLA_B1_HI) |=>
		(!r.req.wr && r.st == MLA_ST_IDLE))
		else $error("external operand moved");
	a_b2_move: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_EXEC && r.op == MLA_OP_LOAD_ADD_MOVE && r.dma >= MLA_B2_LO &&
		r.dma <= MLA_B2_HI) |=> r.req.wr)
		else $error("block two move missing");
	a_mac_sum: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.st == MLA_ST_FETCH_P && !ovf) |=>
		(r.acc == $past(r.acc) + $past(shifted)))
		else $error("mac sum wrong");
endmodule : mla_core
`default_nettype wire

// ===== pkg/mla_pkg.sv
// Purpose: shared constants and types for the multiplicand load block
// Assumes: 16-bit data words, 32-bit accumulator and product
// Notes:   register offsets for the plain command port
package mla_pkg;
	// Register offsets on the command port
	localparam logic [3:0] MLA_OFS_CTRL   = 4'h0;
	localparam logic [3:0] MLA_OFS_ACC_LO = 4'h1;
	localparam logic [3:0] MLA_OFS_ACC_HI = 4'h2;
	localparam logic [3:0] MLA_OFS_FACTOR = 4'h3;
	localparam logic [3:0] MLA_OFS_PROD_LO = 4'h4;
	localparam logic [3:0] MLA_OFS_PROD_HI = 4'h5;
	localparam logic [3:0] MLA_OFS_STATUS = 4'h6;
	// Control field positions
	localparam int MLA_CTRL_PM_LSB  = 0;
	localparam int MLA_CTRL_SAT_BIT = 2;
	localparam int MLA_CTRL_CNF_BIT = 3;
	// Status field positions
	localparam int MLA_STAT_C_BIT  = 0;
	localparam int MLA_STAT_OV_BIT = 1;
	localparam int MLA_STAT_BSY_BIT = 2;
	// Reset values
	localparam logic [15:0] MLA_CTRL_RST = 16'h0000;
	// Memory map of the data space
	localparam logic [15:0] MLA_MMR_TOP  = 16'h0005;
	localparam logic [15:0] MLA_B2_LO    = 16'h0060;
	localparam logic [15:0] MLA_B2_HI    = 16'h007F;
	localparam logic [15:0] MLA_B0_LO    = 16'h0200;
	localparam logic [15:0] MLA_B1_HI    = 16'h03FF;
	localparam logic [15:0] MLA_B0_HI    = 16'h02FF;
	// Memory access latency, cycles
	localparam int MLA_MEM_LAT = 1;

	typedef enum logic [2:0] {
		MLA_OP_LOAD_FACTOR,
		MLA_OP_LOAD_ADD,
		MLA_OP_LOAD_ADD_MOVE,
		MLA_OP_LOAD_SUB,
		MLA_OP_LOAD_COPY,
		MLA_OP_MULACC
	} mla_op_t;

	// Instruction issued by the decoder
	typedef struct packed {
		logic        valid;
		mla_op_t     op;
		logic [15:0] dma;
		logic [15:0] pma;
		logic [7:0]  repeat_count;
	} mla_cmd_t;

	// Memory request toward data and program memory
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        prog;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mla_mem_req_t;
endpackage : mla_pkg

// ===== rtl/mla_shift.sv
// Purpose: product shifter driven by the product shift mode
// Assumes: 32-bit product in two's complement
// Notes:   purely combinational
`timescale 1ns/1ns
`default_nettype none
module mla_shift (
	input  wire logic [31:0] product,
	input  wire logic [1:0]  product_shift_mode,
	output logic      [31:0] shifted
);
	// Mode 0 none, 1 left 1, 2 left 4, 3 right 6 arithmetic
	always_comb begin
		case (product_shift_mode)
			2'h1:    shifted = {product[30:0], 1'b0};
			2'h2:    shifted = {product[27:0], 4'h0};
			2'h3:    shifted = {{6{product[31]}}, product[31:6]};
			default: shifted = product;
		endcase
	end
endmodule : mla_shift
`default_nettype wire

// ===== tb/mla_mem_model.sv
// Purpose: data and program memory beside the load block
// Assumes: one request a cycle, read data while the registered request stands
// Notes:   idle read lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module mla_mem_model
	import mla_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire mla_pkg::mla_mem_req_t mem_req,
	output var  logic [15:0]           mem_rdata
);
	logic [15:0] dm [0:65535];
	logic [15:0] pm [0:65535];
	logic [15:0] last_rdata;
	initial last_rdata = 16'h0000;
	// Answer the standing read, idle lines show the inverse of the last answer
	always_comb begin
		if (mem_req.rd)
			mem_rdata = mem_req.prog ? pm[mem_req.addr] : dm[mem_req.addr];
		else
			mem_rdata = ~last_rdata;
	end
	// Remember the last answer, store data writes
	always @(posedge sys_clk) begin
		if (mem_req.rd)
			last_rdata <= mem_rdata;
		if (mem_req.wr && !mem_req.prog)
			dm[mem_req.addr] <= mem_req.wdata;
	end
endmodule : mla_mem_model
`default_nettype wire

// ===== tb/mla_core_bench.sv
// Purpose: self-checking bench for the multiplicand load block
// Assumes: memory model answers one cycle after a read request
// Notes:   integer reference model compared after every command
`timescale 1ns/1ns
`default_nettype none
module mla_core_bench;
	import mla_pkg::*;
	logic         sys_clk, nrst, busy, reg_wr, reg_rd, cy, ov;
	logic [3:0]   reg_addr;
	logic [15:0]  mem_rdata, reg_wdata, reg_rdata, ctrl, fac;
	logic [31:0]  acc, prod;
	logic [15:0]  xdm [0:65535];
	mla_cmd_t     cmd;
	mla_mem_req_t mem_req;
	int           error_cnt, total_checks;
	mla_op_t      ops [5] = '{MLA_OP_LOAD_FACTOR, MLA_OP_LOAD_ADD, MLA_OP_LOAD_SUB,
		MLA_OP_LOAD_COPY, MLA_OP_LOAD_ADD_MOVE};
	logic [15:0]  ma [8] = '{16'h0065, 16'h02FF, 16'h02FF, 16'h0250, 16'h0310, 16'h03FF,
		16'h0003, 16'h1234};
	logic [15:0]  mc [8] = '{16'h0000, 16'h0000, 16'h0008, 16'h0008, 16'h0009, 16'h0006,
		16'h0000, 16'h0002};

	mla_core dut (.sys_clk(sys_clk), .nrst(nrst), .cmd(cmd), .busy(busy), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	mla_mem_model mdl (.sys_clk(sys_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

	// Core clock, 100 MHz
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [31:0] shp(input logic [31:0] p);
		case (ctrl[1:0])
			2'h0: return p;
			2'h1: return p << 1;
			2'h2: return p << 4;
			default: return $signed(p) >>> 6;
		endcase
	endfunction : shp

	function automatic logic moves(input logic [15:0] a);
		return (a >= MLA_B2_LO && a <= MLA_B2_HI) || (a > MLA_B0_HI && a < MLA_B1_HI)
			|| (a >= MLA_B0_LO && a <= MLA_B0_HI && !ctrl[MLA_CTRL_CNF_BIT]);
	endfunction : moves

	// Add or subtract into the accumulator with flags and saturation
	task automatic accum(input logic [31:0] b, input logic sub);
		logic [32:0] s;
		logic [31:0] bb;
		bb = sub ? ~b : b;
		s = {1'b0, acc} + {1'b0, bb} + {32'h00000000, sub};
		cy = s[32];
		if (acc[31] == bb[31] && s[31] != acc[31]) begin
			ov = 1'b1;
			if (ctrl[MLA_CTRL_SAT_BIT])
				s[31:0] = acc[31] ? 32'h80000000 : 32'h7FFFFFFF;
		end
		acc = s[31:0];
	endtask : accum

	// Reference behaviour of one command
	task automatic ref_op(input mla_op_t op, input logic [15:0] a, input logic [15:0] pa,
		input int rc);
		logic [15:0] d;
		d = xdm[a];
		fac = d;
		case (op)
			MLA_OP_LOAD_ADD, MLA_OP_LOAD_ADD_MOVE: accum(shp(prod), 1'b0);
			MLA_OP_LOAD_SUB: accum(shp(prod), 1'b1);
			MLA_OP_LOAD_COPY: acc = shp(prod);
			MLA_OP_MULACC: for (int i = 0; i <= rc; i++) begin
				accum(shp(prod), 1'b0);
				prod = $signed(d) * $signed(mdl.pm[16'(pa + i)]);
			end
			default: ;
		endcase
		if (op == MLA_OP_LOAD_ADD_MOVE && moves(a))
			xdm[a + 16'h0001] = d;
	endtask : ref_op

	////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd

	task automatic setc(input logic [15:0] v);
		ctrl = v;
		wr(MLA_OFS_CTRL, v);
	endtask : setc

	task automatic check_all;
		rd(MLA_OFS_ACC_LO, acc[15:0]);
		rd(MLA_OFS_ACC_HI, acc[31:16]);
		rd(MLA_OFS_FACTOR, fac);
		rd(MLA_OFS_PROD_LO, prod[15:0]);
		rd(MLA_OFS_PROD_HI, prod[31:16]);
		rd(MLA_OFS_STATUS, {14'h0000, ov, cy});
	endtask : check_all

	// One command; pile offers a second one while busy
	task automatic issue(input mla_op_t op, input logic [15:0] a, input logic [15:0] pa,
		input int rc, input logic pile);
		@(posedge sys_clk);
		cmd <= '{1'b1, op, a, pa, 8'(rc)};
		@(posedge sys_clk);
		cmd.valid <= pile;
		cmd.op <= MLA_OP_LOAD_COPY;
		@(posedge sys_clk);
		cmd.valid <= 1'b0;
		#1;
		for (int n = 0; n < 400 && busy !== 1'b0; n++) begin
			@(posedge sys_clk);
			#1;
		end
		chk({15'h0000, busy}, 16'h0000);
		repeat (2) @(posedge sys_clk);
		ref_op(op, a, pa, rc);
	endtask : issue

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	// Watchdog against a hang
	initial begin
		repeat (30000) @(posedge sys_clk);
		error_cnt++;
		complete_run();
	end

	////////////////////////////////////////
	initial begin
		{nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		cmd = '0;
		{acc, prod, fac, ctrl, cy, ov} = '0;
		error_cnt = 0;
		total_checks = 0;
		void'($urandom(32'hE0145DA6));
		for (int i = 0; i < 65536; i++) begin
			xdm[i] = 16'($urandom);
			mdl.dm[i] = xdm[i];
			mdl.pm[i] = 16'($urandom);
		end
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(MLA_OFS_CTRL, MLA_CTRL_RST);
		wr(4'hA, 16'($urandom));
		rd(4'hA, 16'h0000);
		check_all();
		$display("test reset done");
		for (int m = 0; m < 8; m++) begin
			setc(16'(m));
			issue(MLA_OP_MULACC, 16'h0300 + 16'($urandom_range(254)), 16'($urandom), 0, 1'b0);
			check_all();
			for (int k = 0; k < 5; k++) begin
				issue(ops[k], 16'h0060 + 16'($urandom_range(30)), 16'h0000, 0, 1'b0);
				check_all();
			end
		end
		$display("test modes done");
		for (int k = 0; k < 8; k++) begin
			setc(mc[k]);
			issue(MLA_OP_LOAD_ADD_MOVE, ma[k], 16'h0000, 0, 1'b0);
			chk(mdl.dm[ma[k] + 16'h0001], xdm[ma[k] + 16'h0001]);
			check_all();
		end
		$display("test moves done");
		setc(16'h0008);
		issue(MLA_OP_MULACC, 16'h0310, 16'hFF00 + 16'($urandom_range(200)), 3, 1'b0);
		check_all();
		issue(MLA_OP_MULACC, 16'h0065, 16'($urandom), 7, 1'b0);
		check_all();
		issue(MLA_OP_LOAD_FACTOR, 16'h0070, 16'h0000, 0, 1'b1);
		check_all();
		$display("test repeat done");
		complete_run();
	end
endmodule : mla_core_bench
`default_nettype wire
